// >>> src/acc_cond_if.sv
// Interface between the register logic and the comparator output conditioner.
// Assumes both ends run on the same system clock.
`timescale 1ns/100ps
`default_nettype none
interface acc_cond_if;
    logic enable;
    logic filter_en;
    logic invert;
    logic level;
    logic rise;
    logic fall;
    modport ctrl (output enable, filter_en, invert, input level, rise, fall);
    modport cond (input enable, filter_en, invert, output level, rise, fall);
endinterface
`default_nettype wire

// >>> src/acc_ctrl.sv
// Comparator control and status registers behind an AXI4-Lite slave.
// Assumes an asynchronous comparator output and a one-cycle service pulse.
//
// Notes on behaviour
// R1 - Reference select routes reference, swapped by exchange.
// R2 - Level field: off, quarter or half supply.
// R3 - Power bit off means output is invalid.
// R4 - Three-bit code picks channels one to seven.
// R5 - Two-bit code picks channels zero to two.
// R6 - Filter bit routes output through filter.
// R7 - Output bit is read-only, writes ignored.
// R8 - Exchange swaps terminals and inverts output.
// R9 - Flag set on edge chosen by select.
// R10 - Flag request needs flag, enable and global enable; masked event status also requests, without global enable.
// R11 - Short bit joins plus and minus inputs.
// R12 - Control bits reset to zero, drive outputs.
`timescale 1ns/100ps
`default_nettype none
module acc_ctrl (
    // Clock and reset
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    // AXI4-Lite write channels
    input  wire logic [acc_pkg::ADDR_W-1:0] awaddr,
    input  wire logic                      awvalid,
    output logic                           awready,
    input  wire logic [31:0]               wdata,
    input  wire logic [3:0]                wstrb,
    input  wire logic                      wvalid,
    output logic                           wready,
    output logic [1:0]                     bresp,
    output logic                           bvalid,
    input  wire logic                      bready,
    // AXI4-Lite read channels
    input  wire logic [acc_pkg::ADDR_W-1:0] araddr,
    input  wire logic                      arvalid,
    output logic                           arready,
    output logic [31:0]                    rdata,
    output logic [1:0]                     rresp,
    output logic                           rvalid,
    input  wire logic                      rready,
    // Analog side
    input  wire logic                      comp_raw,
    output logic                           comparator_power_on,
    output logic                           input_exchange,
    output logic                           input_short,
    output logic [1:0]                     reference_level,
    output logic                           ref_on_minus,
    output logic [7:0]                     plus_chan_sel,
    output logic [7:0]                     minus_chan_sel,
    output logic                           output_filter_enable,
    // Interrupt
    input  wire logic                      irq_ack,
    output logic                           irq
);
    import acc_pkg::*;

    acc_cond_if cif ();

    logic [ADDR_W-1:0] aw_addr_r;
    logic              aw_held_r;
    logic [7:0]        w_data_r;
    logic              w_lane_r;
    logic              w_held_r;
    logic              aw_hs;
    logic              w_hs;
    logic              ar_hs;
    logic              wr_do;
    logic              wr_lane;
    logic [7:0]        comparator_control_one_r;
    logic [7:0]        comparator_control_two_r;
    logic [7:0]        ctl1_nxt;
    logic [7:0]        ctl2_nxt;
    logic              evt_stat_r;
    logic              evt_mask_r;
    logic              gie_r;
    logic              edge_evt;
    logic [7:0]        oh2;
    logic [7:0]        oh3;
    logic [1:0]        code2;
    logic [2:0]        code3;
    logic [7:0]        rd_byte;
    logic              rd_ok;

    // ------------------------------------------------------------
    // Output conditioner
    // ------------------------------------------------------------
    acc_out_cond u_cond (
        .aclk    (aclk),
        .aresetn (aresetn),
        .comp_raw(comp_raw),
        .c       (cif.cond)
    );

    assign cif.enable    = comparator_power_on;                       // [R3]
    assign cif.filter_en = output_filter_enable;                      // [R6]
    assign cif.invert    = input_exchange;                            // [R8]
    assign edge_evt = comparator_control_one_r[IES_B] ? cif.fall : cif.rise; // [R9]

    // ------------------------------------------------------------
    // Write address and data channels
    // ------------------------------------------------------------
    assign aw_hs   = awvalid & awready;
    assign w_hs    = wvalid & wready;
    assign ar_hs   = arvalid & arready;
    assign wr_do   = aw_held_r & w_held_r & ~bvalid;
    assign wr_lane = wr_do & w_lane_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            aw_addr_r <= '0;
            awready   <= 1'b0;
        end else begin
            if (aw_hs) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= awaddr;
            end else if (wr_do) begin
                aw_held_r <= 1'b0;
            end
            awready <= ~((aw_held_r & ~wr_do) | aw_hs);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_r <= 1'b0;
            w_data_r <= 8'h00;
            w_lane_r <= 1'b0;
            wready   <= 1'b0;
        end else begin
            if (w_hs) begin
                w_held_r <= 1'b1;
                w_data_r <= wdata[7:0];
                w_lane_r <= wstrb[0];
            end else if (wr_do) begin
                w_held_r <= 1'b0;
            end
            wready <= ~((w_held_r & ~wr_do) | w_hs);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= RESP_OKAY;
        end else if (wr_do) begin
            bvalid <= 1'b1;
            bresp  <= (aw_addr_r == CTL1_ADDR || aw_addr_r == CTL2_ADDR ||
                       aw_addr_r == EVT_STAT_ADDR || aw_addr_r == EVT_MASK_ADDR ||
                       aw_addr_r == GIE_ADDR) ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always_comb begin
        ctl1_nxt = comparator_control_one_r;
        ctl2_nxt = comparator_control_two_r;
        if (irq_ack) begin
            ctl1_nxt[IFG_B] = 1'b0;                                   // [R10]
        end
        if (wr_lane && aw_addr_r == CTL1_ADDR) begin
            ctl1_nxt = w_data_r;
        end
        if (wr_lane && aw_addr_r == CTL2_ADDR) begin
            ctl2_nxt[7:1] = w_data_r[7:1];                            // [R7]
        end
        if (edge_evt) begin
            ctl1_nxt[IFG_B] = 1'b1;                                   // [R9]
        end
        ctl2_nxt[OUT_B] = cif.level;                                  // [R7]
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            comparator_control_one_r <= CTL_RST;                      // [R12]
            comparator_control_two_r <= CTL_RST;                      // [R12]
        end else begin
            comparator_control_one_r <= ctl1_nxt;
            comparator_control_two_r <= ctl2_nxt;
        end
    end

    // ------------------------------------------------------------
    // Analog controls
    // ------------------------------------------------------------
    always_comb begin
        code2 = {ctl2_nxt[PSH_B], ctl2_nxt[PSL_B]};
        code3 = ctl2_nxt[MS_HI:MS_LO];
        oh2   = (code2 == 2'h0) ? 8'h00 : ONE_HOT_0 << (code2 - 2'h1); // [R5]
        oh3   = (code3 == 3'h0) ? 8'h00 : ONE_HOT_0 << code3;          // [R4]
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            comparator_power_on  <= 1'b0;
            input_exchange       <= 1'b0;
            input_short          <= 1'b0;
            reference_level      <= 2'h0;
            ref_on_minus         <= 1'b0;
            plus_chan_sel        <= 8'h00;
            minus_chan_sel       <= 8'h00;
            output_filter_enable <= 1'b0;
        end else begin
            comparator_power_on  <= ctl1_nxt[PWR_B];                  // [R3] [R12]
            input_exchange       <= ctl1_nxt[EXCH_B];                 // [R8]
            input_short          <= ctl2_nxt[SHORT_B];                // [R11]
            reference_level      <= ctl1_nxt[REF_HI:REF_LO];          // [R2]
            ref_on_minus         <= ctl1_nxt[RSEL_B] ^ ctl1_nxt[EXCH_B]; // [R1]
            plus_chan_sel        <= ctl1_nxt[EXCH_B] ? oh3 : oh2;     // [R4] [R5] [R8]
            minus_chan_sel       <= ctl1_nxt[EXCH_B] ? oh2 : oh3;     // [R4] [R5] [R8]
            output_filter_enable <= ctl2_nxt[FILT_B];                 // [R6]
        end
    end

    // ------------------------------------------------------------
    // Event status, mask, global enable and interrupt
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            evt_stat_r <= 1'b0;
        end else if (edge_evt) begin
            evt_stat_r <= 1'b1;
        end else if (wr_lane && aw_addr_r == EVT_STAT_ADDR && w_data_r[0]) begin
            evt_stat_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            evt_mask_r <= 1'b0;
            gie_r      <= 1'b0;
        end else begin
            if (wr_lane && aw_addr_r == EVT_MASK_ADDR) begin
                evt_mask_r <= w_data_r[0];
            end
            if (wr_lane && aw_addr_r == GIE_ADDR) begin
                gie_r <= w_data_r[0];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= (ctl1_nxt[IFG_B] & ctl1_nxt[IE_B] & gie_r) |       // [R10]
                   (evt_stat_r & evt_mask_r);
        end
    end

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    always_comb begin
        rd_ok   = 1'b1;
        rd_byte = 8'h00;
        case (araddr)
            CTL1_ADDR:     rd_byte = comparator_control_one_r;
            CTL2_ADDR:     rd_byte = {comparator_control_two_r[7:1], cif.level}; // [R7]
            EVT_STAT_ADDR: rd_byte = {7'h00, evt_stat_r};
            EVT_MASK_ADDR: rd_byte = {7'h00, evt_mask_r};
            GIE_ADDR:      rd_byte = {7'h00, gie_r};
            default:       rd_ok   = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= RESP_OKAY;
        end else begin
            arready <= ~ar_hs & ~(rvalid & ~rready);
            if (ar_hs) begin
                rvalid <= 1'b1;
                rdata  <= {24'h00_0000, rd_byte};
                rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    ref_route_a: assert property (                                    // [R1]
        ref_on_minus == (comparator_control_one_r[RSEL_B] ^ comparator_control_one_r[EXCH_B]))
        else $error("Reference routed to wrong terminal.");

    ref_level_a: assert property (                                    // [R2]
        reference_level == comparator_control_one_r[REF_HI:REF_LO])
        else $error("Reference level differs from its field.");

    power_gate_a: assert property (                                   // [R3]
        !comparator_power_on ##1 !comparator_power_on |-> !cif.level)
        else $error("Output level seen while comparator is off.");

    minus_code_a: assert property (                                   // [R4]
        !comparator_control_one_r[EXCH_B] && comparator_control_two_r[MS_HI:MS_LO] == 3'h7
        |-> minus_chan_sel == 8'h80 && !plus_chan_sel[7])
        else $error("Three-bit code did not pick channel seven.");

    plus_code_a: assert property (                                    // [R5]
        !comparator_control_one_r[EXCH_B] && comparator_control_two_r[PSH_B]
        && !comparator_control_two_r[PSL_B] |-> plus_chan_sel == 8'h02)
        else $error("Two-bit code did not pick channel one.");

    filter_sel_a: assert property (                                   // [R6]
        output_filter_enable == comparator_control_two_r[FILT_B])
        else $error("Filter enable differs from its bit.");

    out_read_a: assert property (                                     // [R7]
        ar_hs && araddr == CTL2_ADDR |=> rdata[OUT_B] == $past(cif.level))
        else $error("Output bit read back wrong level.");

    exch_swap_a: assert property (                                    // [R8]
        comparator_control_one_r[EXCH_B] && comparator_control_two_r[MS_HI:MS_LO] == 3'h1
        |-> plus_chan_sel == 8'h02 && cif.invert)
        else $error("Exchange did not swap and invert.");

    flag_edge_a: assert property (                                    // [R9]
        edge_evt |=> comparator_control_one_r[IFG_B] && evt_stat_r)
        else $error("Selected edge did not set the flag.");

    irq_req_a: assert property (                                      // [R10]
        comparator_control_one_r[IFG_B] && comparator_control_one_r[IE_B] && gie_r
        && !irq_ack && !(wr_lane && aw_addr_r == CTL1_ADDR) |=> irq)
        else $error("Enabled pending flag raised no request.");

    short_sw_a: assert property (                                     // [R11]
        input_short == comparator_control_two_r[SHORT_B])
        else $error("Short switch differs from its bit.");

    reset_zero_a: assert property (disable iff (1'b0)                 // [R12]
        !aresetn |=> comparator_control_one_r == CTL_RST && !comparator_power_on
        && comparator_control_two_r[7:1] == 7'h00)
        else $error("Control bits not cleared by reset.");
endmodule
`default_nettype wire

// >>> src/acc_out_cond.sv
// Comparator output conditioner: synchroniser, filter, inversion and edge pulses.
// Assumes the raw comparator output is asynchronous to the clock.
`timescale 1ns/100ps
`default_nettype none
module acc_out_cond (
    // Clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // Analog side
    input  wire logic comp_raw,
    // Register side
    acc_cond_if.cond  c
);
    import acc_pkg::*;

    logic       sync1_r;
    logic       sync2_r;
    logic       filt_r;
    logic [3:0] cnt_r;
    logic       lvl_nxt;

    // ------------------------------------------------------------
    // Synchroniser and filter
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end else begin
            sync1_r <= comp_raw;
            sync2_r <= sync1_r;
        end
    end

    // The filtered level follows the input only after it has held steady.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            filt_r <= 1'b0;
            cnt_r  <= 4'h0;
        end else if (sync2_r == filt_r) begin
            cnt_r <= 4'h0;
        end else if (cnt_r == FILT_MAX) begin
            filt_r <= sync2_r;
            cnt_r  <= 4'h0;
        end else begin
            cnt_r <= cnt_r + 4'h1;
        end
    end

    // ------------------------------------------------------------
    // Level and edges
    // ------------------------------------------------------------
    always_comb begin
        lvl_nxt = c.enable & ((c.filter_en ? filt_r : sync2_r) ^ c.invert); // [R3] [R6] [R8]
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            c.level <= 1'b0;
            c.rise  <= 1'b0;
            c.fall  <= 1'b0;
        end else begin
            c.level <= lvl_nxt;
            c.rise  <= lvl_nxt & ~c.level;
            c.fall  <= ~lvl_nxt & c.level;
        end
    end
endmodule
`default_nettype wire

// >>> src/acc_pkg.sv
// Constants for the comparator control block: register map, bit fields, timing.
// Assumes a 50 MHz system clock and a 32-bit AXI4-Lite register bus.
package acc_pkg;
    // ------------------------------------------------------------
    // Bus and register map
    // ------------------------------------------------------------
    localparam int          ADDR_W        = 12;
    localparam logic [11:0] CTL1_IDX      = 12'h059;
    localparam logic [11:0] CTL2_IDX      = 12'h05a;
    localparam logic [11:0] CTL1_ADDR     = 12'(CTL1_IDX * 4);
    localparam logic [11:0] CTL2_ADDR     = 12'(CTL2_IDX * 4);
    localparam logic [11:0] EVT_STAT_ADDR = 12'h170;
    localparam logic [11:0] EVT_MASK_ADDR = 12'h174;
    localparam logic [11:0] GIE_ADDR      = 12'h178;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
    localparam logic [7:0]  CTL_RST       = 8'h00;
    localparam logic [7:0]  ONE_HOT_0     = 8'h01;

    // ------------------------------------------------------------
    // Control register one fields
    // ------------------------------------------------------------
    localparam int EXCH_B  = 7;
    localparam int RSEL_B  = 6;
    localparam int REF_HI  = 5;
    localparam int REF_LO  = 4;
    localparam int PWR_B   = 3;
    localparam int IES_B   = 2;
    localparam int IE_B    = 1;
    localparam int IFG_B   = 0;

    // ------------------------------------------------------------
    // Control register two fields
    // ------------------------------------------------------------
    localparam int SHORT_B = 7;
    localparam int PSH_B   = 6;
    localparam int MS_HI   = 5;
    localparam int MS_LO   = 3;
    localparam int PSL_B   = 2;
    localparam int FILT_B  = 1;
    localparam int OUT_B   = 0;

    // ------------------------------------------------------------
    // Output filter timing
    // ------------------------------------------------------------
    localparam int         CLK_NS   = 20;
    localparam int         FILT_NS  = 100;
    localparam int         FILT_CYC = (FILT_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0] FILT_MAX = 4'(FILT_CYC - 1);
endpackage

// >>> test/acc_comp_model.sv
// Behavioural comparator on the analog side of the control block.
// Assumes the bench sets plus_gt_minus to the sign of the input difference.
`timescale 1ns/100ps
`default_nettype none
module acc_comp_model (
    // Clock
    input  wire logic aclk,
    // Controls from the block
    input  wire logic comparator_power_on,
    input  wire logic input_exchange,
    // Stimulus and result
    input  wire logic plus_gt_minus,
    output var  logic comp_raw
);
    logic junk_r = 1'b0;

    // Powered off, the output is meaningless and wanders every cycle.
    always @(posedge aclk) begin
        junk_r <= ~junk_r;
    end

    // Swapped inputs turn the raw decision round.
    assign comp_raw = comparator_power_on ? (plus_gt_minus ^ input_exchange) : junk_r;
endmodule
`default_nettype wire

// >>> test/testbench.sv
// Self-checking bench for the comparator control block over AXI4-Lite.
// Assumes the behavioural comparator model stands on the analog side.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import acc_pkg::*;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, irq_ack, diff;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, reference_level, r;
    logic        awready, wready, bvalid, arready, rvalid, comp_raw, comparator_power_on;
    logic        input_exchange, input_short, ref_on_minus, output_filter_enable, irq;
    logic [7:0]  plus_chan_sel, minus_chan_sel, pe, me;
    int          err_total = 0;
    int          n_tests   = 0;

    acc_ctrl uut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready, .comp_raw, .comparator_power_on, .input_exchange, .input_short,
        .reference_level, .ref_on_minus, .plus_chan_sel, .minus_chan_sel,
        .output_filter_enable, .irq_ack, .irq);
    acc_comp_model model (.aclk, .comparator_power_on, .input_exchange,
        .plus_gt_minus(diff), .comp_raw);

    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic end_of_test;
        $display("Counts: %0d compares, %0d mismatches", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic bound(input int n);
        if (n >= 64) begin
            err_total++;
            $display("Bus wait ran out at %0t", $time);
            end_of_test();
        end
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask

    task automatic axw(input logic [11:0] a, input logic [7:0] v, output logic [1:0] rs);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= {24'h000000, v};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (awready === 1'b1 && wready === 1'b1) break;
        end while ((awvalid || wvalid) && n < 64);
        while (bvalid !== 1'b1 && n < 64) begin
            @(posedge aclk);
            n++;
        end
        rs = bresp;
        bready <= 1'b0;
        bound(n);
    endtask

    task automatic axr(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
        int n;
        n = 0;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
        end while (arready !== 1'b1 && n < 64);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1 && n < 64) begin
            @(posedge aclk);
            n++;
        end
        v = rdata;
        rs = rresp;
        rready <= 1'b0;
        bound(n);
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        axw(a, v, r);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        axr(a, d, r);
        chk({d[31:2], r}, {exp[31:2], RESP_OKAY});
        chk(d, exp);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        rdc(CTL1_ADDR, 32'h00000000);
        rdc(CTL2_ADDR, 32'h00000000);
        chk({plus_chan_sel, minus_chan_sel, reference_level, input_short, irq}, 0);
        $display("Test reset done");
    endtask

    task automatic t_ref;
        logic [3:0] v;
        for (int i = 0; i < 16; i++) begin
            v = 4'(i);
            wr(CTL1_ADDR, {v, 4'h0});
            chk({input_exchange, ref_on_minus, reference_level}, {v[3], v[3] ^ v[2], v[1:0]});
            chk(comparator_power_on, 1'b0);
            rdc(CTL1_ADDR, {24'h000000, v, 4'h0});
        end
        wr(CTL1_ADDR, 8'h00);
        $display("Test reference done");
    endtask

    task automatic t_mux;
        logic [2:0] m;
        logic [1:0] p;
        for (int i = 0; i < 32; i++) begin
            m = 3'(i >> 2);
            p = 2'(i);
            pe = (p == 2'h0) ? 8'h00 : 8'(8'h01 << (p - 2'h1));
            me = (m == 3'h0) ? 8'h00 : 8'(8'h01 << m);
            wr(CTL2_ADDR, {m[0], p[1], m, p[0], m[1], 1'b0});
            chk({plus_chan_sel, minus_chan_sel}, {pe, me});
            chk({input_short, output_filter_enable}, {m[0], m[1]});
            wr(CTL1_ADDR, 8'h80);
            chk({plus_chan_sel, minus_chan_sel}, {me, pe});
            wr(CTL1_ADDR, 8'h00);
        end
        $display("Test input select done");
    endtask

    task automatic t_out;
        wr(CTL2_ADDR, 8'h00);
        wr(CTL1_ADDR, 8'h08);
        chk(comparator_power_on, 1'b1);
        diff <= 1'b1;
        wait_cyc(10);
        rdc(CTL2_ADDR, 32'h00000001);
        wr(CTL2_ADDR, 8'h00);
        rdc(CTL2_ADDR, 32'h00000001);
        wr(CTL1_ADDR, 8'h88);
        wait_cyc(10);
        rdc(CTL2_ADDR, 32'h00000001);
        wr(CTL1_ADDR, 8'h00);
        wait_cyc(10);
        rdc(CTL2_ADDR, 32'h00000000);
        diff <= 1'b0;
        wr(CTL2_ADDR, 8'h02);
        wr(CTL1_ADDR, 8'h08);
        wait_cyc(10);
        wr(EVT_STAT_ADDR, 8'h01);
        diff <= 1'b1;
        wait_cyc(3);
        diff <= 1'b0;
        wait_cyc(10);
        rdc(EVT_STAT_ADDR, 32'h00000000);
        rdc(CTL2_ADDR, 32'h00000002);
        diff <= 1'b1;
        wait_cyc(12);
        rdc(CTL2_ADDR, 32'h00000003);
        $display("Test output level done");
    endtask

    task automatic t_irq;
        diff <= 1'b0;
        wr(CTL2_ADDR, 8'h00);
        wr(CTL1_ADDR, 8'h0a);
        wr(GIE_ADDR, 8'h01);
        wr(EVT_MASK_ADDR, 8'h00);
        wr(EVT_STAT_ADDR, 8'h01);
        wait_cyc(10);
        chk(irq, 1'b0);
        diff <= 1'b1;
        wait_cyc(10);
        chk(irq, 1'b1);
        rdc(CTL1_ADDR, 32'h0000000b);
        irq_ack <= 1'b1;
        @(posedge aclk);
        irq_ack <= 1'b0;
        wait_cyc(3);
        chk(irq, 1'b0);
        rdc(CTL1_ADDR, 32'h0000000a);
        wr(CTL1_ADDR, 8'h0e);
        diff <= 1'b0;
        wait_cyc(10);
        rdc(CTL1_ADDR, 32'h0000000f);
        wr(CTL1_ADDR, 8'h0e);
        wait_cyc(2);
        chk(irq, 1'b0);
        wr(GIE_ADDR, 8'h00);
        diff <= 1'b1;
        wait_cyc(10);
        rdc(CTL1_ADDR, 32'h0000000e);
        diff <= 1'b0;
        wait_cyc(10);
        rdc(CTL1_ADDR, 32'h0000000f);
        chk(irq, 1'b0);
        rdc(EVT_STAT_ADDR, 32'h00000001);
        wr(EVT_MASK_ADDR, 8'h01);
        wait_cyc(2);
        chk(irq, 1'b1);
        wr(EVT_STAT_ADDR, 8'h01);
        wait_cyc(2);
        chk(irq, 1'b0);
        axw(12'h300, 8'hff, r);
        chk(r, RESP_SLVERR);
        axr(12'h300, d, r);
        chk({d, r}, {32'h00000000, RESP_SLVERR});
        $display("Test interrupt done");
    endtask

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, irq_ack, diff} = 8'h00;
        {awaddr, araddr, wdata} = 56'h0;
        wstrb = 4'hf;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_reset();
        t_ref();
        t_mux();
        t_out();
        t_irq();
        end_of_test();
    end
endmodule
`default_nettype wire
